// ### core/octal_input_debounce_alarm.sv
// octal field-input debounce filter with supply and temperature alarms
// assumes all inputs synchronous to clk_sys_i and a register master that
// never issues read and write strobes together
//
// How it works
// - each channel is filtered with no filtering, 25 us, 0.75 ms or 3 ms.
// - select pins decode high bit first: 00 none, 01 25 us, 10 0.75 ms, 11 3 ms.
// - in a filtered mode a new level is accepted only after three equal consecutive samples.
// - the sampling tick period is a third of the selected debounce time.
// - in a filtered mode a change that does not last three samples is dropped and the output holds.
// - a channel's comparator result is 1 for sensor active and 0 for sensor inactive.
// - each filtered channel drives its own logic output bit.
// - over-temperature asserts the combined alarm.
// - supply undervoltage asserts the supply-low and combined alarms.
// - supply alarms release only when the supply-recovered level is seen.
// - powered from the 5V pin both supply alarm and combined alarm stay asserted.
// - both alarms are active low and the combined one is the OR of both causes.
`timescale 1ns/1ns
`include "debounce_map.svh"

module octal_input_debounce_alarm #(
  parameter int unsigned N_CH       = 8,
  parameter int unsigned TICK_SHORT = `TICK_CYC(`DB_SHORT_NS),
  parameter int unsigned TICK_MID   = `TICK_CYC(`DB_MID_NS),
  parameter int unsigned TICK_LONG  = `TICK_CYC(`DB_LONG_NS),
  parameter int unsigned DIV_W      = 18
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // field side
  input  wire logic [N_CH-1:0]   field_inputs_i,
  input  wire logic              debounce_sel_low_i,
  input  wire logic              debounce_sel_high_i,
  // monitors
  input  wire logic              over_temp_i,
  input  wire logic              supply_fall_i,
  input  wire logic              supply_rise_i,
  input  wire logic              ext5v_powered_i,
  // controller side
  output logic [N_CH-1:0]        logic_outputs_o,
  output logic                   supply_low_alarm_n_o,
  output logic                   fault_alarm_n_o,
  output logic                   irq_o,
  // register port
  input  wire logic [3:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic [31:0]            rdata_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  debounce_pkg::db_sel_t       sel_d;
  debounce_pkg::db_sel_t       sel_q;
  debounce_pkg::supply_state_t sup_d;
  debounce_pkg::supply_state_t sup_q;
  debounce_pkg::status_t       status_d;
  debounce_pkg::status_t       status_q;
  debounce_pkg::status_t       mask_d;
  debounce_pkg::status_t       mask_q;
  debounce_pkg::status_t       event_set;
  logic [DIV_W-1:0]            div_q;
  logic [DIV_W-1:0]            div_load;
  logic                        tick_q;
  logic [N_CH-1:0]             out_d;
  logic [N_CH-1:0]             out_q;
  logic [N_CH-1:0]             cand_q;
  logic [1:0]                  cnt_q [N_CH];
  logic                        ot_q;
  logic                        ot_live;
  logic                        low_n_q;
  logic                        fault_n_q;
  logic                        irq_q;
  logic [31:0]                 rdata_q;

  // ************************************************************
  // sampling tick divider
  // ************************************************************

  // pin decode, high bit first
  assign sel_d = debounce_pkg::db_sel_t'({debounce_sel_high_i, debounce_sel_low_i});

  // reload value for the selected sampling period
  always_comb
  begin
    case (sel_q)
      debounce_pkg::DB_SHORT: div_load = DIV_W'(TICK_SHORT - 1);
      debounce_pkg::DB_MID:   div_load = DIV_W'(TICK_MID - 1);
      debounce_pkg::DB_LONG:  div_load = DIV_W'(TICK_LONG - 1);
      default:                div_load = '0;
    endcase
  end

  // latch the selection
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sel_q <= debounce_pkg::DB_NONE;
    else
      sel_q <= sel_d;
  end

  // count down, tick at zero, restart when the selection changes
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (sel_d != sel_q)
    begin
      div_q  <= '1;        // held off until the new load below
      tick_q <= 1'b0;
    end
    else if (div_q == '0 || div_q > div_load)
    begin
      div_q  <= div_load;
      tick_q <= (div_q == '0);
    end
    else
    begin
      div_q  <= div_q - DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // ************************************************************
  // per-channel filters
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < N_CH; g++)
    begin : g_ch
      // next output: direct only while unfiltered mode holds, else third equal sample
      always_comb
      begin
        out_d[g] = out_q[g];
        if (sel_q == debounce_pkg::DB_NONE && sel_d == sel_q)
          out_d[g] = field_inputs_i[g];
        else if (tick_q && field_inputs_i[g] == cand_q[g] && cnt_q[g] == 2'h2)
          out_d[g] = cand_q[g];
      end

      // candidate level and its stability counter
      always_ff @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          cand_q[g] <= 1'b0;
          cnt_q[g]  <= 2'h0;
        end
        else if (sel_d != sel_q)
          cnt_q[g]  <= 2'h0;
        else if (tick_q)
        begin
          if (field_inputs_i[g] != cand_q[g])
          begin
            cand_q[g] <= field_inputs_i[g];
            cnt_q[g]  <= 2'h1;
          end
          else if (cnt_q[g] != 2'h3)
            cnt_q[g]  <= cnt_q[g] + 2'h1;
        end
      end
    end
  endgenerate

  // filtered outputs, one bit per channel
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      out_q <= N_CH'(`OUTPUTS_RST);
    else
      out_q <= out_d;
  end

  // ************************************************************
  // supply and temperature alarms
  // ************************************************************

  // supply monitor with hysteresis between fall and rise levels
  always_comb
  begin
    sup_d = sup_q;
    case (sup_q)
      debounce_pkg::SUP_OK:
        if (ext5v_powered_i)
          sup_d = debounce_pkg::SUP_EXT5V;
        else if (supply_fall_i)
          sup_d = debounce_pkg::SUP_LOW;
      debounce_pkg::SUP_LOW:
        if (ext5v_powered_i)
          sup_d = debounce_pkg::SUP_EXT5V;
        else if (supply_rise_i && !supply_fall_i)
          sup_d = debounce_pkg::SUP_OK;
      debounce_pkg::SUP_EXT5V:
        if (!ext5v_powered_i)
          sup_d = debounce_pkg::SUP_LOW;
      default:
        sup_d = debounce_pkg::SUP_LOW;
    endcase
  end

  // temperature reporting is lost when powered from the 5V pin
  assign ot_live = over_temp_i && !ext5v_powered_i;

  // alarm state and active-low pins
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sup_q     <= debounce_pkg::SUP_OK;
      ot_q      <= 1'b0;
      low_n_q   <= 1'b1;
      fault_n_q <= 1'b1;
    end
    else
    begin
      sup_q     <= sup_d;
      ot_q      <= ot_live;
      low_n_q   <= (sup_d == debounce_pkg::SUP_OK);
      fault_n_q <= (sup_d == debounce_pkg::SUP_OK) && !ot_live;
    end
  end

  // ************************************************************
  // status, mask and interrupt
  // ************************************************************

  // events that set sticky bits
  always_comb
  begin
    event_set              = '0;
    event_set.input_change = (out_d != out_q);
    event_set.over_temp    = ot_live && !ot_q;
    event_set.supply_low   = (sup_d != debounce_pkg::SUP_OK)
                             && (sup_q == debounce_pkg::SUP_OK);
    event_set.supply_ok    = (sup_d == debounce_pkg::SUP_OK)
                             && (sup_q != debounce_pkg::SUP_OK);
  end

  // write one to clear, a new event wins over the clear
  always_comb
  begin
    status_d = status_q;
    mask_d   = mask_q;
    if (wr_en_i && addr_i == `REG_STATUS_OFS)
      status_d = status_q & ~debounce_pkg::status_t'(wdata_i[3:0]);
    if (wr_en_i && addr_i == `REG_MASK_OFS)
      mask_d = debounce_pkg::status_t'(wdata_i[3:0]);
    status_d = status_d | event_set;
  end

  // status, mask and level interrupt
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status_q <= `STATUS_RST;
      mask_q   <= `MASK_RST;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= |(status_d & mask_d);
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************

  // read data valid in the cycle after the strobe only
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_q <= 32'h0000_0000;
    else if (!rd_en_i)
      rdata_q <= 32'h0000_0000;
    else
    begin
      rdata_q <= 32'h0000_0000;
      case (addr_i)
        `REG_STATUS_OFS: rdata_q[3:0]      <= status_q;
        `REG_MASK_OFS:   rdata_q[3:0]      <= mask_q;
        `REG_INPUTS_OFS: rdata_q[N_CH-1:0] <= out_q;
        `REG_ALARMS_OFS:
        begin
          rdata_q[`AL_OVER_TEMP]  <= ot_q;
          rdata_q[`AL_SUPPLY_LOW] <= !low_n_q;
          rdata_q[`AL_EXT5V]      <= (sup_q == debounce_pkg::SUP_EXT5V);
          rdata_q[`AL_SEL_LSB+:2] <= sel_q;
        end
        default:         rdata_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  assign logic_outputs_o      = out_q;
  assign supply_low_alarm_n_o = low_n_q;
  assign fault_alarm_n_o      = fault_n_q;
  assign irq_o                = irq_q;
  assign rdata_o              = rdata_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  chk_nofilt_pass: assert property (
    sel_q == debounce_pkg::DB_NONE && sel_d == sel_q |=> logic_outputs_o == $past(field_inputs_i))
    else $error("unfiltered output does not follow input");

  chk_accept_three: assert property (
    (sel_q != debounce_pkg::DB_NONE && $past(sel_q) != debounce_pkg::DB_NONE
     && logic_outputs_o[0] != $past(logic_outputs_o[0]))
    |-> $past(tick_q) && $past(cnt_q[0]) == 2'h2
        && $past(cand_q[0]) == logic_outputs_o[0])
    else $error("filtered output changed without three equal samples");

  chk_glitch_drop: assert property (
    (sel_q != debounce_pkg::DB_NONE && !tick_q) |=> $stable(logic_outputs_o))
    else $error("filtered output changed between ticks");

  chk_tick_gap: assert property (
    (sel_q == debounce_pkg::DB_SHORT && tick_q) |=> !tick_q [*8])
    else $error("sampling ticks too close");

  chk_sel_reload: assert property (
    $changed(sel_q) |-> !tick_q ##1 (div_q == div_load || $changed(sel_q)))
    else $error("divider not reloaded on new selection");

  chk_ot_fault: assert property (
    (over_temp_i && !ext5v_powered_i) |=> !fault_alarm_n_o)
    else $error("over temperature not flagged");
  chk_uv_both: assert property (
    supply_fall_i |=> !supply_low_alarm_n_o && !fault_alarm_n_o)
    else $error("undervoltage not flagged by both alarms");
  chk_uv_hold: assert property (
    (!supply_low_alarm_n_o && !supply_rise_i) |=> !supply_low_alarm_n_o)
    else $error("supply alarm released without recovery");
  chk_ext5v_hold: assert property (
    ext5v_powered_i |=> !supply_low_alarm_n_o && !fault_alarm_n_o)
    else $error("5V powering does not hold alarms");
  chk_fault_or: assert property (
    !supply_low_alarm_n_o |-> !fault_alarm_n_o)
    else $error("combined alarm misses supply low");

  chk_irq_level: assert property (
    irq_o == |(status_q & mask_q))
    else $error("interrupt does not match status and mask");

  cov_filtered_accept: cover property (
    sel_q == debounce_pkg::DB_SHORT && $changed(logic_outputs_o));
  cov_uv_recover: cover property (
    $fell(supply_low_alarm_n_o) ##[1:50] $rose(supply_low_alarm_n_o));
  cov_irq_clear: cover property (
    irq_o ##1 (wr_en_i && addr_i == `REG_STATUS_OFS) ##1 !irq_o);

endmodule : octal_input_debounce_alarm

// ### core/debounce_map.svh
// register offsets, field positions, reset values and timing figures
// assumes a 250 MHz system clock and a 4-bit byte address on the register port
`ifndef DEBOUNCE_MAP_SVH
`define DEBOUNCE_MAP_SVH

// register byte offsets
`define REG_STATUS_OFS   4'h0
`define REG_MASK_OFS     4'h4
`define REG_INPUTS_OFS   4'h8
`define REG_ALARMS_OFS   4'hC

// status and mask field positions
`define ST_INPUT_CHANGE  0
`define ST_OVER_TEMP     1
`define ST_SUPPLY_LOW    2
`define ST_SUPPLY_OK     3

// alarm register field positions
`define AL_OVER_TEMP     0
`define AL_SUPPLY_LOW    1
`define AL_EXT5V         2
`define AL_SEL_LSB       4

// reset values
`define STATUS_RST       4'h0
`define MASK_RST         4'h0
`define OUTPUTS_RST      8'h00

// timing: clock period and debounce times in ns
`define CLK_PERIOD_NS    4
`define DB_SHORT_NS      25000
`define DB_MID_NS        750000
`define DB_LONG_NS       3000000
// sampling period is a third of the debounce time, rounded up to whole cycles
`define TICK_CYC(t)      (((t) + 3 * `CLK_PERIOD_NS - 1) / (3 * `CLK_PERIOD_NS))

`endif

// ### core/debounce_pkg.sv
// types shared by the octal input debounce and alarm block
// assumes the constants of debounce_map.svh for field positions
package debounce_pkg;

  // debounce selection as decoded from the two select pins, high bit first
  typedef enum logic [1:0] {
    DB_NONE  = 2'h0,
    DB_SHORT = 2'h1,
    DB_MID   = 2'h2,
    DB_LONG  = 2'h3
  } db_sel_t;

  // supply monitor state
  typedef enum logic [1:0] {
    SUP_OK,
    SUP_LOW,
    SUP_EXT5V
  } supply_state_t;

  // sticky event bits, same layout as the mask
  typedef struct packed {
    logic supply_ok;
    logic supply_low;
    logic over_temp;
    logic input_change;
  } status_t;

endpackage : debounce_pkg

// ### testbench/controller_model.sv
// far-side controller model: samples the parallel outputs every cycle
// assumes the outputs are registered by clk_sys_i
`timescale 1ns/1ns

module controller_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // device outputs and change count
  input  wire logic [7:0]  logic_outputs_i,
  output logic      [15:0] changes_o
);
  // ************
  // change count
  // ************
  logic [7:0] seen_q;

  // count each cycle in which the parallel word moved
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      seen_q    <= 8'h00;
      changes_o <= 16'h0000;
    end
    else
    begin
      seen_q <= logic_outputs_i;
      if (seen_q != logic_outputs_i)
        changes_o <= changes_o + 16'h0001;
    end
  end
endmodule : controller_model

// ### testbench/tb_octal_input_debounce_alarm.sv
// self-checking bench for the octal debounce and alarm block
// assumes debounce_map.svh in the include path and short tick parameters
`timescale 1ns/1ns
`include "debounce_map.svh"

module tb_octal_input_debounce_alarm;
  // ***********
  // environment
  // ***********
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  field = 8'h00;
  logic        sel_l = 1'b0;
  logic        sel_h = 1'b0;
  logic        over_temp = 1'b0;
  logic        fall = 1'b0;
  logic        rise = 1'b1;
  logic        ext5v = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  outs;
  logic        sup_n;
  logic        fault_n;
  logic        irq;
  logic [31:0] rdata;
  logic [15:0] changes;
  logic [7:0]  exp_out = 8'h00;
  int          errors = 0;
  int          num_checks = 0;

  // 250 MHz system clock
  always #2 clk = ~clk;

  octal_input_debounce_alarm #(
    .TICK_SHORT (10),
    .TICK_MID   (20),
    .TICK_LONG  (30)
  ) octal_input_debounce_alarm_inst (
    .clk_sys_i            (clk),
    .resetn_i             (resetn),
    .field_inputs_i       (field),
    .debounce_sel_low_i   (sel_l),
    .debounce_sel_high_i  (sel_h),
    .over_temp_i          (over_temp),
    .supply_fall_i        (fall),
    .supply_rise_i        (rise),
    .ext5v_powered_i      (ext5v),
    .logic_outputs_o      (outs),
    .supply_low_alarm_n_o (sup_n),
    .fault_alarm_n_o      (fault_n),
    .irq_o                (irq),
    .addr_i               (addr),
    .wdata_i              (wdata),
    .wr_en_i              (wr_en),
    .rd_en_i              (rd_en),
    .rdata_o              (rdata)
  );

  controller_model controller_model_inst (
    .clk_sys_i       (clk),
    .resetn_i        (resetn),
    .logic_outputs_i (outs),
    .changes_o       (changes)
  );

  // *******
  // helpers
  // *******
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask : rd

  task automatic chk_al(input logic [1:0] e);
    chk("alarms", 32'(e), 32'({fault_n, sup_n}));
  endtask : chk_al

  // *********
  // scenarios
  // *********
  task automatic t_nofilt;
    @(posedge clk);
    field <= 8'hA5;
    step(1);
    chk("pass", 32'h0000_00A5, 32'(outs));
    @(posedge clk);
    field   <= 8'h5A;
    exp_out = 8'h5A;
    step(1);
    chk("pass", 32'(exp_out), 32'(outs));
  endtask : t_nofilt

  task automatic t_filter(input logic [1:0] s, input int t);
    logic [15:0] c0;
    @(posedge clk);
    {sel_h, sel_l} <= s;
    step(5);
    c0 = changes;
    // glitch seen by two ticks at most
    @(posedge clk);
    field <= ~exp_out;
    step(2 * t - 1);
    @(posedge clk);
    field <= exp_out;
    step(4 * t);
    chk("glitch", 32'(exp_out), 32'(outs));
    @(posedge clk);
    field <= ~exp_out;
    step(2 * t - 2);
    chk("early", 32'(exp_out), 32'(outs));
    step(t + 5);
    exp_out = ~exp_out;
    chk("accept", 32'(exp_out), 32'(outs));
    chk("changes", 32'(c0 + 16'h0001), 32'(changes));
  endtask : t_filter

  task automatic t_regs;
    wr(`REG_STATUS_OFS, 32'h0000_000F);
    rd(`REG_STATUS_OFS, 32'h0);
    @(posedge clk);
    over_temp <= 1'b1;
    step(2);
    chk("masked irq", 32'h0, 32'(irq));
    rd(`REG_STATUS_OFS, 32'h0000_0002);
    wr(`REG_MASK_OFS, 32'h0000_0002);
    step(2);
    chk("irq", 32'h1, 32'(irq));
    @(posedge clk);
    over_temp <= 1'b0;
    wr(`REG_STATUS_OFS, 32'h0000_0002);
    step(2);
    chk("irq clear", 32'h0, 32'(irq));
    rd(`REG_STATUS_OFS, 32'h0);
    rd(4'h2, 32'h0);
    wr(`REG_INPUTS_OFS, 32'h0000_00FF);
    rd(`REG_INPUTS_OFS, 32'(exp_out));
    rd(`REG_MASK_OFS, 32'h0000_0002);
  endtask : t_regs

  task automatic t_alarms;
    @(posedge clk);
    over_temp <= 1'b1;
    step(1);
    chk_al(2'b01);
    rd(`REG_ALARMS_OFS, 32'h0000_0031);
    @(posedge clk);
    over_temp <= 1'b0;
    rise      <= 1'b0;
    fall      <= 1'b1;
    step(1);
    chk_al(2'b00);
    @(posedge clk);
    fall <= 1'b0;
    step(4);
    chk_al(2'b00);
    @(posedge clk);
    rise <= 1'b1;
    step(1);
    chk_al(2'b11);
    @(posedge clk);
    ext5v     <= 1'b1;
    over_temp <= 1'b1;
    step(5);
    chk_al(2'b00);
    rd(`REG_ALARMS_OFS, 32'h0000_0036);
    @(posedge clk);
    ext5v     <= 1'b0;
    over_temp <= 1'b0;
    step(3);
    chk_al(2'b11);
    rd(`REG_STATUS_OFS, 32'h0000_000E);
    chk("alarm irq", 32'h1, 32'(irq));
  endtask : t_alarms

  // mid-run reset with the slow filter selected: outputs stay 0 until accepted
  task automatic t_reset;
    @(posedge clk);
    resetn <= 1'b0;
    step(2);
    chk("reset out", 32'h0, 32'(outs));
    chk_al(2'b11);
    chk("reset irq", 32'h0, 32'(irq));
    @(posedge clk);
    resetn <= 1'b1;
    step(60);
    chk("held out", 32'h0, 32'(outs));
    step(40);
    chk("settled out", 32'(exp_out), 32'(outs));
    chk("changes", 32'h1, 32'(changes));
    rd(`REG_STATUS_OFS, 32'h0000_0001);
  endtask : t_reset

  // ************
  // verdict
  // ************
  task automatic results;
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end

  // main sequence
  initial
  begin
    step(1);
    chk("reset out", 32'h0, 32'(outs));
    chk_al(2'b11);
    chk("reset irq", 32'h0, 32'(irq));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`REG_INPUTS_OFS, 32'h0);
    rd(`REG_MASK_OFS, 32'h0);
    t_nofilt();
    t_filter(2'h1, 10);
    t_filter(2'h2, 20);
    t_filter(2'h3, 30);
    t_regs();
    t_alarms();
    t_reset();
    results();
  end
endmodule : tb_octal_input_debounce_alarm
